// File: bid_max_selector.sv
`timescale 1ns/10ps
`default_nettype none

// Finds the highest arbitration value among all enabled bids
module bid_max_selector
    import interrupt_context_arbiter_pkg::*;
(
    input  wire logic [3:0]   rx_req_i,   // Receiver bid per channel
    input  wire logic [27:0]  rx_val_i,   // Receiver bid values, 7 each
    input  wire logic [3:0]   rx_err_i,   // Receiver has errors
    input  wire logic [19:0]  rx_cnt_i,   // Receiver fill 1..16, 5 each
    input  wire logic [3:0]   tx_req_i,   // Transmitter bid per channel
    input  wire logic [27:0]  tx_val_i,   // Transmitter bid values
    input  wire logic [19:0]  tx_cnt_i,   // Transmitter free count
    input  wire logic [15:0]  oth_req_i,  // Other bids, chan*4+kind
    input  wire logic [111:0] oth_val_i,  // Other bid values, 7 each
    input  wire logic         wdog_i,     // Watchdog pending somewhere
    output logic              win_valid_o,
    output logic [9:0]        win_value_o,
    output src_t              win_src_o,
    output logic              win_err_o,
    output logic [4:0]        win_cnt_o
);

    // Kinds of other bid, in slot order within one channel
    localparam src_t OTH_KIND [4] = '{SRC_COS, SRC_ADDR, SRC_XON, SRC_BRK};

    // Scan every candidate; the channel number in the low bits breaks ties across channels,
    // and within a channel a strict compare keeps the kind scanned first
    always_comb
    begin
        logic [9:0] cand;
        cand        = 10'h000;
        win_valid_o = 1'b0;
        win_value_o = 10'h000;
        win_src_o   = SRC_NONE;
        win_err_o   = 1'b0;
        win_cnt_o   = 5'h00;
        for (int ch = 0; ch < 4; ch++)
        begin
            // Receivers always take part
            cand = {rx_val_i[ch*7 +: 7], 3'(ch)};
            if (rx_req_i[ch] && (!win_valid_o || cand > win_value_o))
            begin
                win_valid_o = 1'b1;
                win_value_o = cand;
                win_src_o   = SRC_RX;
                win_err_o   = rx_err_i[ch];
                win_cnt_o   = rx_cnt_i[ch*5 +: 5];
            end
            // Non-receivers are shut out while a watchdog is pending
            cand = {tx_val_i[ch*7 +: 7], 3'(ch)};
            if (!wdog_i && tx_req_i[ch]
                && (!win_valid_o || cand > win_value_o))
            begin
                win_valid_o = 1'b1;
                win_value_o = cand;
                win_src_o   = SRC_TX;
                win_err_o   = 1'b0;
                win_cnt_o   = tx_cnt_i[ch*5 +: 5];
            end
            for (int k = 0; k < 4; k++)
            begin
                cand = {oth_val_i[(ch*4+k)*7 +: 7], 3'(ch)};
                if (!wdog_i && oth_req_i[ch*4+k]
                    && (!win_valid_o || cand > win_value_o))
                begin
                    win_valid_o = 1'b1;
                    win_value_o = cand;
                    win_src_o   = OTH_KIND[k];
                    win_err_o   = 1'b0;
                    win_cnt_o   = 5'h00;
                end
            end
        end
    end

endmodule : bid_max_selector

`default_nettype wire

// File: host_bus.sv
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_context_arbiter_defines.svh"

// Host processor: register cycles and acknowledge
module host_bus
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            ack_n_o
);
    // Idle bus at time zero
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        ack_n_o = 1'b1;
    end

    // Released lines flip so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr

    // Data is taken a cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask : rd

    // Acknowledge held low for n cycles
    task automatic ack(input int n);
        @(negedge clk_i);
        ack_n_o = 1'b0;
        repeat (n) @(negedge clk_i);
        ack_n_o = 1'b1;
    endtask : ack

    // Exact fill level of a receiver or transmitter context
    task automatic count(input logic [7:0] c, output logic [4:0] n);
        logic [7:0] b;
        if (c[5:3] == 3'h0)
        begin
            rd(`OFS_BYTE_COUNT, b);
            n = {1'b0, b[3:0]} + 5'h01;
        end
        else
            n = {2'h0, c[5:3]} + 5'h09;
    endtask : count
endmodule : host_bus
`default_nettype wire

// File: ica_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_context_arbiter_defines.svh"

// Port-level checks of the arbiter; sees only its pins
module ica_props
(
    input wire logic         CLK_SYS_I,
    input wire logic         RESETN_I,
    input wire logic [7:0]   ADDR_I,
    input wire logic [7:0]   WDATA_I,
    input wire logic         WR_I,
    input wire logic         RD_I,
    input wire logic [7:0]   RDATA_O,
    input wire logic         IRQ_ACK_N_I,
    input wire logic         IRQ_OUT_N_O,
    input wire logic [2:0]   CTX_CHAN_O,
    input wire logic [3:0]   RX_REQ_I,
    input wire logic [27:0]  RX_VAL_I,
    input wire logic [3:0]   TX_REQ_I,
    input wire logic [27:0]  TX_VAL_I,
    input wire logic [15:0]  OTH_REQ_I,
    input wire logic [111:0] OTH_VAL_I,
    input wire logic [3:0]   WDOG_PEND_I
);
    logic [6:0]   thr_q;  // Shadow of the threshold register
    logic [6:0]   mx;     // Highest live bid value
    logic         any;    // Some bid is live
    wire  [23:0]  rq = {OTH_REQ_I, TX_REQ_I, RX_REQ_I};
    wire  [167:0] vl = {OTH_VAL_I, TX_VAL_I, RX_VAL_I};

    // Shadow follows host writes, so no peeking inside is needed
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            thr_q <= 7'h00;
        else if (WR_I && ADDR_I == `OFS_THRESHOLD)
            thr_q <= WDATA_I[6:0];
    end

    // Highest bid over every source kind
    always_comb
    begin
        mx = 7'h00;
        any = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            if (rq[i] && (!any || vl[7*i +: 7] > mx))
            begin
                any = 1'b1;
                mx = vl[7*i +: 7];
            end
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);

    property p_up;
        (WDOG_PEND_I == 4'h0 && any && mx > thr_q) |=> !IRQ_OUT_N_O;
    endproperty
    a_up: assert property (p_up) else $error("irq missing");
    property p_dn;
        (WDOG_PEND_I == 4'h0 && !(any && mx > thr_q)) |=> IRQ_OUT_N_O;
    endproperty
    a_dn: assert property (p_dn) else $error("irq stuck");
    property p_wdon;
        (WDOG_PEND_I != 4'h0 && RX_REQ_I != 4'h0) |=> !IRQ_OUT_N_O;
    endproperty
    a_wdon: assert property (p_wdon) else $error("wdog irq");
    property p_wdoff;
        (WDOG_PEND_I != 4'h0 && RX_REQ_I == 4'h0) |=> IRQ_OUT_N_O;
    endproperty
    a_wdoff: assert property (p_wdoff) else $error("wdog leak");
    property p_frz;
        !((!IRQ_ACK_N_I && $past(IRQ_ACK_N_I)) ||
          (WR_I && ADDR_I == `OFS_REFRESH)) |=> $stable(CTX_CHAN_O);
    endproperty
    a_frz: assert property (p_frz) else $error("chan moved");
    property p_chan;
        (RD_I && ADDR_I == `OFS_CHANNEL) |=>
            RDATA_O == {5'h00, $past(CTX_CHAN_O)} && !RDATA_O[2];
    endproperty
    a_chan: assert property (p_chan) else $error("chan reg");
    property p_rfz;
        (RD_I && ADDR_I == `OFS_REFRESH) |=> RDATA_O == 8'h00;
    endproperty
    a_rfz: assert property (p_rfz) else $error("cmd reads");
    property p_oth;
        (RD_I && ADDR_I == `OFS_CONTEXT) |=> RDATA_O[7:6] != 2'b00 ||
            !(RDATA_O[5:3] inside {3'h4, 3'h6, 3'h7});
    endproperty
    a_oth: assert property (p_oth) else $error("bad code");
endmodule : ica_props

bind interrupt_context_arbiter ica_props chk_i (
    .CLK_SYS_I   (CLK_SYS_I),
    .RESETN_I    (RESETN_I),
    .ADDR_I      (ADDR_I),
    .WDATA_I     (WDATA_I),
    .WR_I        (WR_I),
    .RD_I        (RD_I),
    .RDATA_O     (RDATA_O),
    .IRQ_ACK_N_I (IRQ_ACK_N_I),
    .IRQ_OUT_N_O (IRQ_OUT_N_O),
    .CTX_CHAN_O  (CTX_CHAN_O),
    .RX_REQ_I    (RX_REQ_I),
    .RX_VAL_I    (RX_VAL_I),
    .TX_REQ_I    (TX_REQ_I),
    .TX_VAL_I    (TX_VAL_I),
    .OTH_REQ_I   (OTH_REQ_I),
    .OTH_VAL_I   (OTH_VAL_I),
    .WDOG_PEND_I (WDOG_PEND_I)
);
`default_nettype wire

// File: interrupt_context_arbiter.sv
`timescale 1ns/10ps
`default_nettype none

`include "interrupt_context_arbiter_defines.svh"

module interrupt_context_arbiter
    import interrupt_context_arbiter_pkg::*;
(
    input  wire logic         CLK_SYS_I,     // 25 MHz system clock
    input  wire logic         RESETN_I,      // Async reset, active low
    // Host register bus
    input  wire logic [7:0]   ADDR_I,        // Byte address
    input  wire logic [7:0]   WDATA_I,       // Write data
    input  wire logic         WR_I,          // Write strobe, one cycle
    input  wire logic         RD_I,          // Read strobe, one cycle
    output logic      [7:0]   RDATA_O,       // Read data, next cycle
    input  wire logic         IRQ_ACK_N_I,   // Acknowledge, active low
    output logic              IRQ_OUT_N_O,   // Interrupt, active low
    output logic      [2:0]   CTX_CHAN_O,    // Steers global FIFOs
    // Bid sources
    input  wire logic [3:0]   RX_REQ_I,
    input  wire logic [27:0]  RX_VAL_I,
    input  wire logic [3:0]   RX_ERR_I,
    input  wire logic [19:0]  RX_CNT_I,
    input  wire logic [3:0]   TX_REQ_I,
    input  wire logic [27:0]  TX_VAL_I,
    input  wire logic [19:0]  TX_CNT_I,
    input  wire logic [15:0]  OTH_REQ_I,
    input  wire logic [111:0] OTH_VAL_I,
    input  wire logic [3:0]   WDOG_PEND_I    // Watchdog per receiver
);

    arb_state_t s_reg;       // Registered state
    arb_state_t s_next;      // Next state

    logic       wdog;        // Any watchdog interrupt pending
    logic       win_valid;   // Some source is bidding
    logic [9:0] win_value;   // Winning arbitration value
    src_t       win_src;     // Kind of winning source
    logic       win_err;     // Winning receiver has errors
    logic [4:0] win_cnt;     // Winning FIFO fill count

    logic       win_above;   // Winner may raise a request
    logic       ack_start;   // First cycle of an acknowledge
    logic       refresh;     // Refresh command written
    logic       update;      // Context register loads this cycle
    logic [7:0] ctx_new;     // Context image of the winner
    logic [7:0] gtype_new;   // Type register image of the winner

    assign wdog = |WDOG_PEND_I;

    // Highest bid across all channels; receivers only while a watchdog is pending
    bid_max_selector u_sel (
        .rx_req_i    (RX_REQ_I),
        .rx_val_i    (RX_VAL_I),
        .rx_err_i    (RX_ERR_I),
        .rx_cnt_i    (RX_CNT_I),
        .tx_req_i    (TX_REQ_I),
        .tx_val_i    (TX_VAL_I),
        .tx_cnt_i    (TX_CNT_I),
        .oth_req_i   (OTH_REQ_I),
        .oth_val_i   (OTH_VAL_I),
        .wdog_i      (wdog),
        .win_valid_o (win_valid),
        .win_value_o (win_value),
        .win_src_o   (win_src),
        .win_err_o   (win_err),
        .win_cnt_o   (win_cnt)
    );

    // Build context and type images from the winner
    always_comb
    begin
        ctx_new   = 8'h00;
        gtype_new = 8'h00;
        // Channel number rides in the low bits of the bid
        ctx_new[`CTX_CHAN_HI:`CTX_CHAN_LO] = win_value[2:0];
        unique case (win_src)
            SRC_RX:
            begin
                // Receiver sets bit 7; bit 6 tells errors
                ctx_new[`CTX_TYPE_HI:`CTX_TYPE_LO] =
                    win_err ? `CTX_TYPE_RX_ERR : `CTX_TYPE_RX_OK;
                ctx_new[`CTX_CODE_HI:`CTX_CODE_LO] =
                    count_code(win_cnt);
                gtype_new[7:6] =
                    win_err ? `GTYPE_RX_ERR : `GTYPE_RX_OK;
            end
            SRC_TX:
            begin
                ctx_new[`CTX_TYPE_HI:`CTX_TYPE_LO] = `CTX_TYPE_TX;
                ctx_new[`CTX_CODE_HI:`CTX_CODE_LO] =
                    count_code(win_cnt);
                gtype_new[5] = 1'b1;
            end
            SRC_COS, SRC_ADDR, SRC_XON, SRC_BRK:
            begin
                // Only the defined other codes can be produced
                ctx_new[`CTX_TYPE_HI:`CTX_TYPE_LO] = `CTX_TYPE_OTHER;
                ctx_new[`CTX_CODE_HI:`CTX_CODE_LO] = other_code(win_src);
                gtype_new[2:0] = other_code(win_src);
            end
            default:
            begin
                // No bidder: whole image stays zero
                ctx_new = 8'h00;
            end
        endcase
    end

    // Threshold compare, acknowledge edge and refresh decode
    always_comb
    begin
        // Unsigned compare on the upper seven bits
        // A pending watchdog bypasses the threshold
        win_above = win_valid
                    && (wdog || (win_value[9:3] > s_reg.thresh));
        // Strobe falling edge marks the start of the cycle
        ack_start = s_reg.ack_d && !IRQ_ACK_N_I;
        // Any write to the refresh address, data ignored
        refresh   = WR_I && (ADDR_I == `OFS_REFRESH);
        // Nothing else moves the context
        update    = ack_start || refresh;
    end

    // Next-state logic for the whole block
    always_comb
    begin
        s_next       = s_reg;
        s_next.ack_d = IRQ_ACK_N_I;
        // Recomputed every cycle, so it drops as soon as no bid beats the threshold,
        // or no receiver bids while a watchdog is pending
        s_next.irq_n = !win_above;

        // Context load on acknowledge or refresh
        if (update)
        begin
            if (win_above)
            begin
                s_next.ctx    = ctx_new;
                // Fill count minus one; meaningless for other kinds
                s_next.bcount = 4'(win_cnt - 5'h01);
                s_next.gtype  = gtype_new;
            end
            else
            begin
                // Unless win_above is set, the context reads all zeros
                s_next.ctx    = 8'h00;
                s_next.bcount = 4'h0;
                s_next.gtype  = 8'h00;
            end
        end

        // Threshold write; bit 7 is not stored
        if (WR_I && (ADDR_I == `OFS_THRESHOLD))
        begin
            s_next.thresh = WDATA_I[6:0];
        end

        // Read mux; data held until the next read
        if (RD_I)
        begin
            unique case (ADDR_I)
                `OFS_THRESHOLD:  s_next.rdata = {1'b0, s_reg.thresh};
                `OFS_CONTEXT:    s_next.rdata = s_reg.ctx;
                // Global registers follow the latched context
                `OFS_BYTE_COUNT: s_next.rdata = {4'h0, s_reg.bcount};
                `OFS_CHANNEL:
                    s_next.rdata = {5'h00,
                                    s_reg.ctx[`CTX_CHAN_HI:`CTX_CHAN_LO]};
                `OFS_TYPE:       s_next.rdata = s_reg.gtype;
                // Unmapped addresses read zero
                default:         s_next.rdata = 8'h00;
            endcase
        end
    end

    // State register; the reset loads constants only
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            s_reg <= '{thresh: `RST_THRESHOLD,
                       ctx:    `RST_CONTEXT,
                       bcount: `RST_BYTE_COUNT,
                       gtype:  `RST_TYPE,
                       ack_d:  1'b1,
                       irq_n:  1'b1,
                       rdata:  `RST_RDATA};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    assign RDATA_O     = s_reg.rdata;
    assign IRQ_OUT_N_O = s_reg.irq_n;
    // Latched channel steers the global FIFO ports outside
    assign CTX_CHAN_O  = s_reg.ctx[`CTX_CHAN_HI:`CTX_CHAN_LO];

endmodule : interrupt_context_arbiter

`default_nettype wire

// File: interrupt_context_arbiter_defines.svh
`ifndef INTERRUPT_CONTEXT_ARBITER_DEFINES_SVH
`define INTERRUPT_CONTEXT_ARBITER_DEFINES_SVH

// Register byte addresses on the host bus
`define OFS_THRESHOLD      8'h84
`define OFS_CONTEXT        8'h85
`define OFS_BYTE_COUNT     8'h86
`define OFS_CHANNEL        8'h87
`define OFS_TYPE           8'h88
`define OFS_REFRESH        8'h8C

// Field layout of the current interrupt context
`define CTX_TYPE_HI        7
`define CTX_TYPE_LO        6
`define CTX_CODE_HI        5
`define CTX_CODE_LO        3
`define CTX_CHAN_HI        2
`define CTX_CHAN_LO        0

// Type field encodings of the current interrupt context
`define CTX_TYPE_OTHER     2'h0
`define CTX_TYPE_TX        2'h1
`define CTX_TYPE_RX_OK     2'h2
`define CTX_TYPE_RX_ERR    2'h3

// Code field for other-type interrupts
`define OTH_CODE_NONE      3'h0
`define OTH_CODE_COS       3'h1
`define OTH_CODE_ADDR      3'h2
`define OTH_CODE_XON       3'h3
`define OTH_CODE_BRK       3'h5

// Type register field encodings
`define GTYPE_RX_ERR       2'h2
`define GTYPE_RX_OK        2'h3

// Character count at or below which the count code reads zero
`define COUNT_CODE_BASE    5'h09

// Reset values
`define RST_THRESHOLD      7'h00
`define RST_CONTEXT        8'h00
`define RST_BYTE_COUNT     4'h0
`define RST_TYPE           8'h00
`define RST_RDATA          8'h00

`endif

// File: interrupt_context_arbiter_pkg.sv
`include "interrupt_context_arbiter_defines.svh"

package interrupt_context_arbiter_pkg;

    // Kind of bidding source that is winning arbitration
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_RX   = 3'b001,
        SRC_TX   = 3'b010,
        SRC_COS  = 3'b011,
        SRC_ADDR = 3'b100,
        SRC_XON  = 3'b101,
        SRC_BRK  = 3'b110
    } src_t;

    // Whole state of the top module
    typedef struct packed {
        logic [6:0] thresh;   // Arbitration threshold
        logic [7:0] ctx;      // Current interrupt context
        logic [3:0] bcount;   // Latched byte count minus one
        logic [7:0] gtype;    // Latched type register image
        logic       ack_d;    // Acknowledge strobe, one cycle late
        logic       irq_n;    // Interrupt request, active low
        logic [7:0] rdata;    // Read data held for the host
    } arb_state_t;

    // Count code: 9 or fewer reads 0, 10..16 read 1..7
    function automatic logic [2:0] count_code(input logic [4:0] cnt);
        logic [4:0] diff;
        diff = 5'h00;
        if (cnt > `COUNT_CODE_BASE)
            diff = cnt - `COUNT_CODE_BASE;
        return diff[2:0];
    endfunction : count_code

    // Code field for an other-type source
    function automatic logic [2:0] other_code(input src_t src);
        logic [2:0] code;
        code = `OTH_CODE_NONE;
        unique case (src)
            SRC_COS:  code = `OTH_CODE_COS;
            SRC_ADDR: code = `OTH_CODE_ADDR;
            SRC_XON:  code = `OTH_CODE_XON;
            SRC_BRK:  code = `OTH_CODE_BRK;
            default:  code = `OTH_CODE_NONE;
        endcase
        return code;
    endfunction : other_code

endpackage : interrupt_context_arbiter_pkg

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_context_arbiter_defines.svh"

module tb;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    wire  [7:0]   addr, wdata, rdata;
    wire          wr, rd, ack_n, irq_n;
    wire  [2:0]   chan;
    logic [3:0]   rx_req, rx_err, tx_req, wdog;
    logic [27:0]  rx_val, tx_val;
    logic [19:0]  rx_cnt, tx_cnt;
    logic [15:0]  oth_req;
    logic [111:0] oth_val;
    int           fail_count, n_checks, cyc, w;
    int           kind[4];  // 0 none, 1 rx, 2 tx, 3..6 other kinds
    bit   [6:0]   val[4];
    bit   [4:0]   cnt[4];
    bit           err[4];
    bit   [6:0]   thr;
    bit           wd;
    logic [31:0]  s = 32'h0000_4058;
    logic [7:0]   d, ec, et;
    logic [4:0]   n, en;
    logic [2:0]   oc[4] = '{3'h1, 3'h2, 3'h3, 3'h5};

    always #20 clk = ~clk;

    interrupt_context_arbiter uut (
        .CLK_SYS_I(clk), .RESETN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_ACK_N_I(ack_n),
        .IRQ_OUT_N_O(irq_n), .CTX_CHAN_O(chan), .RX_REQ_I(rx_req),
        .RX_VAL_I(rx_val), .RX_ERR_I(rx_err), .RX_CNT_I(rx_cnt),
        .TX_REQ_I(tx_req), .TX_VAL_I(tx_val), .TX_CNT_I(tx_cnt),
        .OTH_REQ_I(oth_req), .OTH_VAL_I(oth_val), .WDOG_PEND_I(wdog));
    host_bus host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .ack_n_o(ack_n));

    // Hang guard, well above the length of the run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // One bid per channel at most, so winners never tie
    task automatic roll();
        for (int c = 0; c < 4; c++)
        begin
            kind[c] = int'(xs() % 7);
            val[c] = 7'(xs());
            cnt[c] = 5'(xs() % 16 + 1);
            err[c] = 1'(xs());
        end
        wd = (xs() % 4 == 0);
        thr = 7'(xs());
    endtask : roll

    // Idle value fields carry noise; only the request bits count
    task automatic apply();
        rx_val = 28'(xs());
        tx_val = 28'(xs());
        oth_val = {4{28'(xs())}};
        rx_req = 4'h0;
        tx_req = 4'h0;
        oth_req = 16'h0000;
        wdog = wd ? 4'h1 << (xs() % 4) : 4'h0;
        for (int c = 0; c < 4; c++)
        begin
            rx_val[7*c +: 7] = val[c];
            tx_val[7*c +: 7] = val[c];
            rx_cnt[5*c +: 5] = cnt[c];
            tx_cnt[5*c +: 5] = cnt[c];
            rx_err[c] = err[c];
            if (kind[c] == 1)
                rx_req[c] = 1'b1;
            else if (kind[c] == 2)
                tx_req[c] = 1'b1;
            else if (kind[c] > 2)
            begin
                oth_req[4*c + kind[c] - 3] = 1'b1;
                oth_val[7*(4*c + kind[c] - 3) +: 7] = val[c];
            end
        end
    endtask : apply

    // Winner and the context image it should leave behind
    task automatic predict();
        logic [2:0] cc;
        w = -1;
        for (int c = 0; c < 4; c++)
            if (kind[c] != 0 && (wd ? kind[c] == 1 : val[c] > thr) &&
                (w < 0 || {val[c], 2'(c)} > {val[w], 2'(w)}))
                w = c;
        ec = 8'h00;
        et = 8'h00;
        if (w < 0)
            return;
        en = cnt[w];
        cc = 3'(en > 5'h09 ? en - 5'h09 : 5'h00);
        if (kind[w] == 1)
            ec = {1'b1, err[w], cc, 3'(w)};
        else if (kind[w] == 2)
            ec = {2'b01, cc, 3'(w)};
        else
            ec = {2'b00, oc[kind[w] - 3], 3'(w)};
        et = kind[w] == 1 ? {1'b1, ~err[w], 6'h00} :
             kind[w] == 2 ? 8'h20 : {5'h00, ec[5:3]};
    endtask : predict

    initial
    begin
        apply();
        repeat (20) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        host.rd(`OFS_THRESHOLD, d);
        chk("thr", d, 8'h00);
        host.rd(`OFS_CONTEXT, d);
        chk("ctx", d, 8'h00);
        host.rd(8'h90, d);
        chk("unmapped", d, 8'h00);
        host.rd(`OFS_REFRESH, d);
        chk("refresh", d, 8'h00);
        for (int i = 0; i < 80; i++)
        begin
            roll();
            if (i % 2 == 0)
                thr = val[i / 2 % 4] - 7'(i % 4 == 0);
            host.wr(`OFS_THRESHOLD, {1'(xs()), thr});
            host.rd(`OFS_THRESHOLD, d);
            chk("thr", d, {1'b0, thr});
            apply();
            repeat (3) @(negedge clk);
            predict();
            chk("irq", {7'h00, irq_n}, {7'h00, 1'(w < 0)});
            // Bids change half a cycle after the context loads, no later than the command ends
            fork
                if (i % 3 == 0)
                    host.wr(`OFS_REFRESH, 8'(xs()));
                else
                    host.ack(1 + i % 4);
                begin
                    repeat (2) @(negedge clk);
                    roll();
                    apply();
                end
            join
            repeat (2) @(negedge clk);
            host.rd(`OFS_CONTEXT, d);
            chk("ctx", d, ec);
            chk("pin", {5'h00, chan}, {5'h00, ec[2:0]});
            host.rd(`OFS_CHANNEL, d);
            chk("gchan", d, {5'h00, ec[2:0]});
            host.rd(`OFS_TYPE, d);
            chk("gtype", d, et);
            if (ec[7:6] != 2'b00)
            begin
                host.count(ec, n);
                chk("count", {3'h0, n}, {3'h0, en});
            end
        end
        give_verdict();
    end
endmodule : tb
`default_nettype wire
